// ### hdl/dpsem_pkg.sv
//----------------------------------------------------------------
// Summary of operation
// RL1: eight flags in own space, chosen by flag_space_select low and three index lines.
// RL2: on a write only data bit zero counts; low requests, high releases.
// RL3: a low written into a free flag reads zero here, one on the far side.
// RL4: while a side holds a flag, only that side may change it.
// RL5: owner writing high with no opposite request frees the flag for both.
// RL6: non-owner low request is latched until the owner frees the flag.
// RL7: owner release with opposite request pending hands the token over at once.
// RL8: new owner's flag stays low until it writes a high itself.
// RL9: a pending or failed requester reads one although its latch holds low.
// RL10: a read spreads the flag onto all data lines.
// RL11: the read value is latched while select and output enable stay active.
// RL12: a polling loop must drop select or output enable between reads.
// RL13: of two requests on a free flag, the earlier one wins.
// RL14: simultaneous requests give the token to exactly one side.
// RL15: claim by writing low first, then read back to confirm.
// RL16: after a failed claim keep reading or write high to withdraw.
// RL17: at start every flag is written high from this side.
//----------------------------------------------------------------
package dpsem_pkg;
  localparam int unsigned DPSEM_FLAGS = 8;
  localparam int unsigned DPSEM_IDX_W = 3;
  localparam int unsigned DPSEM_DATA_W = 18;
  localparam logic DPSEM_REQUEST = 1'b0;
  localparam logic DPSEM_RELEASE = 1'b1;
  // pin timing, in ns, and cycles at 200 MHz
  localparam int unsigned DPSEM_CLK_PS = 5000;
  localparam int unsigned DPSEM_T_STROBE_NS = 20;
  localparam int unsigned DPSEM_T_GAP_NS = 10;
  localparam logic [3:0] DPSEM_STROBE_CYC =
    4'((DPSEM_T_STROBE_NS * 1000 + DPSEM_CLK_PS - 1) / DPSEM_CLK_PS);
  localparam logic [3:0] DPSEM_GAP_CYC =
    4'((DPSEM_T_GAP_NS * 1000 + DPSEM_CLK_PS - 1) / DPSEM_CLK_PS);
  localparam logic [2:0] DPSEM_IDX_LAST = 3'h7;
  typedef enum logic [2:0] {
    DPSEM_ST_INIT = 3'b000,
    DPSEM_ST_IDLE = 3'b001,
    DPSEM_ST_WRITE = 3'b011,
    DPSEM_ST_READ = 3'b010,
    DPSEM_ST_GAP = 3'b110
  } dpsem_state_e;
endpackage

// ### hdl/dpsem_host.sv
`timescale 1ns/1ps
module dpsem_host
  import dpsem_pkg::*;
(
  // clock, reset, enable
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic enable_i,
  // user command side
  input wire logic cmd_valid_i,
  input wire logic [1:0] cmd_op_i,
  input wire logic [2:0] cmd_index_i,
  output logic cmd_ready_o,
  output logic done_o,
  output logic owned_o,
  output logic init_done_o,
  // device pins
  output logic flag_space_select_n_o,
  output logic write_n_o,
  output logic out_enable_n_o,
  output logic [2:0] flag_index_lines_o,
  output logic [DPSEM_DATA_W-1:0] data_o,
  output logic data_oe_n_o,
  input wire logic [DPSEM_DATA_W-1:0] data_i
);
  // cmd_op_i: 0 claim (write low, read back), 1 release, 2 poll read
  dpsem_state_e state_reg;
  logic [3:0] count_reg;
  logic [2:0] idx_reg;
  logic claim_reg;
  logic read_after_reg;
  logic level_reg;
  logic [3:0] init_writes_reg;

  //----------------------------------------------------------------
  // sequencer
  //----------------------------------------------------------------
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= DPSEM_ST_INIT;
      count_reg <= 4'h0;
      idx_reg <= 3'h0;
      read_after_reg <= 1'b0;
      level_reg <= DPSEM_RELEASE;
      claim_reg <= 1'b0;
      init_done_o <= 1'b0;
    end else if (enable_i) begin
      case (state_reg)
        DPSEM_ST_INIT: begin
          // free every flag from this side before any use
          level_reg <= DPSEM_RELEASE; // RL17
          read_after_reg <= 1'b0;
          count_reg <= DPSEM_STROBE_CYC;
          state_reg <= DPSEM_ST_WRITE;
        end
        DPSEM_ST_IDLE: begin
          if (cmd_valid_i && cmd_op_i != 2'h3) begin
            idx_reg <= cmd_index_i;
            claim_reg <= (cmd_op_i == 2'h0);
            level_reg <= (cmd_op_i == 2'h0) ? DPSEM_REQUEST : DPSEM_RELEASE; // RL16
            // claim is write then read, never read then write
            read_after_reg <= (cmd_op_i == 2'h0); // RL15
            count_reg <= DPSEM_STROBE_CYC;
            state_reg <= (cmd_op_i == 2'h2) ? DPSEM_ST_READ : DPSEM_ST_WRITE;
          end
        end
        DPSEM_ST_WRITE: begin
          if (count_reg > 4'h1) begin
            count_reg <= count_reg - 4'h1;
          end else begin
            // the read-back gets a full strobe so the latched flag settles
            count_reg <= read_after_reg ? DPSEM_STROBE_CYC : DPSEM_GAP_CYC;
            state_reg <= read_after_reg ? DPSEM_ST_READ : DPSEM_ST_GAP;
            if (!init_done_o && !read_after_reg) begin
              idx_reg <= idx_reg + 3'h1;
            end
          end
        end
        DPSEM_ST_READ: begin
          if (count_reg > 4'h1) begin
            count_reg <= count_reg - 4'h1;
          end else begin
            count_reg <= DPSEM_GAP_CYC;
            state_reg <= DPSEM_ST_GAP;
          end
        end
        DPSEM_ST_GAP: begin
          // strobes go inactive here so the device latch refreshes
          if (count_reg > 4'h1) begin
            count_reg <= count_reg - 4'h1; // RL12
          end else if (!init_done_o) begin
            if (idx_reg == 3'h0) begin
              init_done_o <= 1'b1;
              state_reg <= DPSEM_ST_IDLE;
            end else begin
              count_reg <= DPSEM_STROBE_CYC;
              state_reg <= DPSEM_ST_WRITE;
            end
          end else begin
            state_reg <= DPSEM_ST_IDLE;
          end
        end
        default: begin
          state_reg <= DPSEM_ST_INIT;
        end
      endcase
    end
  end

  //----------------------------------------------------------------
  // pins, all registered
  //----------------------------------------------------------------
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      flag_space_select_n_o <= 1'b1;
      write_n_o <= 1'b1;
      out_enable_n_o <= 1'b1;
      flag_index_lines_o <= 3'h0;
      data_o <= '1;
      data_oe_n_o <= 1'b1;
    end else if (enable_i) begin
      flag_index_lines_o <= idx_reg; // RL1
      flag_space_select_n_o <= !(state_reg == DPSEM_ST_WRITE || state_reg == DPSEM_ST_READ);
      write_n_o <= (state_reg != DPSEM_ST_WRITE);
      out_enable_n_o <= (state_reg != DPSEM_ST_READ);
      data_oe_n_o <= (state_reg != DPSEM_ST_WRITE);
      // only bit zero matters; the rest copy it for a clean bus
      data_o <= {DPSEM_DATA_W{level_reg}}; // RL2
    end
  end

  //----------------------------------------------------------------
  // results
  //----------------------------------------------------------------
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      owned_o <= 1'b0;
      done_o <= 1'b0;
      cmd_ready_o <= 1'b0;
    end else if (enable_i) begin
      cmd_ready_o <= (state_reg == DPSEM_ST_IDLE) && !(cmd_valid_i && cmd_op_i != 2'h3);
      done_o <= init_done_o && (state_reg == DPSEM_ST_GAP) && (count_reg == 4'h1);
      // sample on the last read cycle while the device latch holds
      if (state_reg == DPSEM_ST_READ && count_reg == 4'h1) begin
        owned_o <= (data_i[0] == 1'b0); // RL9
      end else if (state_reg == DPSEM_ST_WRITE && !claim_reg) begin
        owned_o <= 1'b0;
      end
    end
  end

  //----------------------------------------------------------------
  // start-up bookkeeping, read only by the checks
  //----------------------------------------------------------------
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      init_writes_reg <= 4'h0;
    end else if (enable_i && !init_done_o) begin
      if (state_reg == DPSEM_ST_WRITE && count_reg == 4'h1) begin
        init_writes_reg <= init_writes_reg + 4'h1;
      end
    end
  end

  //----------------------------------------------------------------
  // checks: start-up
  //----------------------------------------------------------------
  AST_INIT_WRITES_HIGH: assert property (@(posedge clock_i) disable iff (reset_i) // RL17
    (!init_done_o && !write_n_o) |-> data_o[0] == DPSEM_RELEASE)
    else $error("init wrote a request");
  AST_INIT_ENDS: assert property (@(posedge clock_i) disable iff (reset_i) // RL17
    (enable_i && $rose(init_done_o)) |-> state_reg == DPSEM_ST_IDLE)
    else $error("init ended off idle");
  AST_INIT_COUNT: assert property (@(posedge clock_i) disable iff (reset_i) // RL17
    $rose(init_done_o) |-> init_writes_reg == 4'(DPSEM_FLAGS))
    else $error("init did not write every flag");

  //----------------------------------------------------------------
  // checks: commands
  //----------------------------------------------------------------
  AST_CLAIM_THEN_READ: assert property (@(posedge clock_i) disable iff (reset_i) // RL15
    (enable_i && claim_reg && $rose(write_n_o) && init_done_o) |=> !out_enable_n_o)
    else $error("claim write not followed by read");
  AST_CLAIM_DRIVES_LOW: assert property (@(posedge clock_i) disable iff (reset_i) // RL15
    (init_done_o && claim_reg && !write_n_o) |-> data_o[0] == DPSEM_REQUEST)
    else $error("claim wrote a release");
  AST_RELEASE_DRIVES_HIGH: assert property (@(posedge clock_i) disable iff (reset_i) // RL16
    (init_done_o && !claim_reg && !write_n_o) |-> data_o[0] == DPSEM_RELEASE)
    else $error("release wrote a request");
  AST_RELEASE_CLEARS_OWNED: assert property (@(posedge clock_i) disable iff (reset_i) // RL16
    (init_done_o && !claim_reg && !write_n_o) |-> !owned_o)
    else $error("owned kept across a release");
  AST_OWNED_FROM_BIT0: assert property (@(posedge clock_i) disable iff (reset_i) // RL9
    (enable_i && state_reg == DPSEM_ST_READ && count_reg == 4'h1)
      |=> owned_o == !$past(data_i[0]))
    else $error("owned not taken from flag");
  AST_GAP_BETWEEN_READS: assert property (@(posedge clock_i) disable iff (reset_i) // RL12
    $rose(out_enable_n_o) |-> flag_space_select_n_o)
    else $error("select held across reads");

  //----------------------------------------------------------------
  // checks: pins
  //----------------------------------------------------------------
  AST_WR_RD_EXCLUSIVE: assert property (@(posedge clock_i) disable iff (reset_i) // RL2
    !(!write_n_o && !out_enable_n_o))
    else $error("write and read strobes together");
  AST_DRIVE_ON_WRITE: assert property (@(posedge clock_i) disable iff (reset_i) // RL1
    !write_n_o |-> !data_oe_n_o && !flag_space_select_n_o)
    else $error("write without drive or select");
  AST_DRIVE_ONLY_ON_WRITE: assert property (@(posedge clock_i) disable iff (reset_i) // RL2
    !data_oe_n_o |-> !write_n_o)
    else $error("data driven outside a write");
  AST_IDLE_RELEASED: assert property (@(posedge clock_i) disable iff (reset_i) // RL1
    flag_space_select_n_o |-> write_n_o && out_enable_n_o && data_oe_n_o)
    else $error("strobe active without select");
  AST_INDEX_STABLE: assert property (@(posedge clock_i) disable iff (reset_i) // RL1
    (!flag_space_select_n_o && $past(!flag_space_select_n_o) && enable_i)
      |-> $stable(flag_index_lines_o))
    else $error("index moved during access");
  // scenarios worth seeing
  COV_CLAIM_OWNED: cover property (@(posedge clock_i) disable iff (reset_i) $rose(owned_o));
  COV_INIT_DONE: cover property (@(posedge clock_i) disable iff (reset_i) $rose(init_done_o));
  COV_RELEASE: cover property (@(posedge clock_i) disable iff (reset_i) $fell(owned_o));
  COV_FAILED_CLAIM: cover property (@(posedge clock_i) disable iff (reset_i)
    claim_reg && state_reg == DPSEM_ST_READ && count_reg == 4'h1 && data_i[0]);
endmodule

// ### bench/dpsem_dev_model.sv
`timescale 1ns/1ps
module dpsem_dev_model
  import dpsem_pkg::*;
(
  // left port pins
  input wire logic clock_i,
  input wire logic sel_n_i,
  input wire logic wr_n_i,
  input wire logic oe_n_i,
  input wire logic [2:0] idx_i,
  input wire logic [DPSEM_DATA_W-1:0] dat_i,
  input wire logic dat_oe_n_i,
  output logic [DPSEM_DATA_W-1:0] dat_o,
  // right port, driven by the bench
  input wire logic r_wr_i,
  input wire logic [2:0] r_idx_i,
  input wire logic r_dat_i,
  output logic r_flag_o
);
  // no power-up init: left latches start as stale requests
  logic [7:0] req_l = 8'h00;
  logic [7:0] req_r = 8'hff;
  logic [1:0] own [8] = '{default: 2'h0};
  logic rd_act = 1'b0;
  logic [DPSEM_DATA_W-1:0] rd_reg = '0;
  // acts on the falling edge so the host's registered pins and its sampling edge never race
  always @(negedge clock_i) begin
    if (!sel_n_i && !wr_n_i && !dat_oe_n_i) req_l[idx_i] = dat_i[0];
    if (r_wr_i) req_r[r_idx_i] = r_dat_i;
    for (int i = 0; i < 8; i++) begin
      case (own[i])
        2'h0: own[i] = !req_l[i] ? 2'h1 : (!req_r[i] ? 2'h2 : 2'h0);
        2'h1: if (req_l[i]) own[i] = req_r[i] ? 2'h0 : 2'h2;
        default: if (req_r[i]) own[i] = req_l[i] ? 2'h0 : 2'h1;
      endcase
    end
    if (!sel_n_i && !oe_n_i && !rd_act) rd_reg = {DPSEM_DATA_W{own[idx_i] != 2'h1}};
    rd_act = !sel_n_i && !oe_n_i;
  end
  // released bus shows the inverse so a stale value is never mistaken for data
  assign dat_o = rd_act ? rd_reg : ~rd_reg;
  assign r_flag_o = own[r_idx_i] != 2'h2;
endmodule

// ### bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import dpsem_pkg::*;
  logic clock_i = 0, reset_i = 1, enable_i = 0, cmd_valid_i = 0;
  logic [1:0] cmd_op_i = 0;
  logic [2:0] cmd_index_i = 0;
  logic cmd_ready_o, done_o, owned_o, init_done_o, sel_n, wr_n, oe_n, doe_n;
  logic [2:0] idx;
  logic [DPSEM_DATA_W-1:0] d_o, d_i;
  logic r_wr = 0, r_dat = 1, r_flag;
  int miscompares = 0, num_checks = 0;
  // rows: right action, op, index, expected owned
  logic [7:0] rows [8] = '{8'h01, 8'h61, 8'h10, 8'h00, 8'ha1, 8'h10, 8'h0f, 8'h1e};
  dpsem_host i_dpsem_host(.clock_i(clock_i), .reset_i(reset_i), .enable_i(enable_i),
    .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_index_i(cmd_index_i),
    .cmd_ready_o(cmd_ready_o), .done_o(done_o), .owned_o(owned_o),
    .init_done_o(init_done_o), .flag_space_select_n_o(sel_n), .write_n_o(wr_n),
    .out_enable_n_o(oe_n), .flag_index_lines_o(idx), .data_o(d_o),
    .data_oe_n_o(doe_n), .data_i(d_i));
  dpsem_dev_model i_dpsem_dev_model(.clock_i(clock_i), .sel_n_i(sel_n), .wr_n_i(wr_n),
    .oe_n_i(oe_n), .idx_i(idx), .dat_i(d_o), .dat_oe_n_i(doe_n), .dat_o(d_i),
    .r_wr_i(r_wr), .r_idx_i(cmd_index_i), .r_dat_i(r_dat), .r_flag_o(r_flag));
  initial forever #2.5 clock_i = ~clock_i;
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_sig(ref logic s, input int lim);
    int n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(posedge clock_i);
      n++;
    end
    chk(18'(n < lim), 18'h1);
  endtask
  task automatic cmd(input logic [1:0] op, input logic [2:0] ix);
    wait_sig(cmd_ready_o, 40);
    @(posedge clock_i);
    cmd_valid_i <= 1;
    cmd_op_i <= op;
    cmd_index_i <= ix;
    @(posedge clock_i);
    cmd_valid_i <= 0;
    wait_sig(done_o, 40);
  endtask
  task automatic test_done();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #50000;
    miscompares++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge clock_i);
    reset_i <= 0;
    enable_i <= 1;
    wait_sig(init_done_o, 200);
    foreach (rows[i]) begin
      @(posedge clock_i);
      cmd_index_i <= rows[i][3:1];
      r_dat <= rows[i][7:6] != 2'h1;
      r_wr <= rows[i][7:6] != 2'h0;
      @(posedge clock_i);
      r_wr <= 0;
      cmd(rows[i][5:4], rows[i][3:1]);
      @(posedge clock_i);
      chk(18'(owned_o), 18'(rows[i][0]));
    end
    chk(18'(r_flag), 18'h1);
    // frozen enable must hold a poll in mid read
    @(posedge clock_i);
    cmd_valid_i <= 1;
    cmd_op_i <= 2'h2;
    @(posedge clock_i);
    cmd_valid_i <= 0;
    repeat (2) @(posedge clock_i);
    enable_i <= 0;
    @(posedge clock_i);
    repeat (6) begin
      @(posedge clock_i);
      chk({15'h0, sel_n, oe_n, done_o}, 18'h0);
    end
    enable_i <= 1;
    wait_sig(done_o, 40);
    chk(18'(owned_o), 18'h0);
    // op 3 must be ignored
    @(posedge clock_i);
    cmd_valid_i <= 1;
    cmd_op_i <= 2'h3;
    repeat (20) begin
      @(posedge clock_i);
      chk({16'h0, done_o, sel_n}, 18'h1);
    end
    // reset in mid command
    cmd_op_i <= 2'h0;
    repeat (4) @(posedge clock_i);
    reset_i <= 1;
    @(posedge clock_i);
    #1 chk({15'h0, sel_n, wr_n, oe_n}, 18'h7);
    // second start-up: its writes must free the flag cut mid-claim, so the right request wins
    @(posedge clock_i);
    reset_i <= 0;
    cmd_valid_i <= 0;
    wait_sig(init_done_o, 200);
    @(posedge clock_i);
    r_dat <= 0;
    r_wr <= 1;
    @(posedge clock_i);
    r_wr <= 0;
    @(posedge clock_i);
    chk(18'(r_flag), 18'h0);
    test_done();
  end
endmodule
